// ### include/trim_bank_cfg.svh
// constants for the converter offset and fine-gain trim bank
// Function
// RQ1: core A phase-90 input B offset, calibration only
// RQ2: core B input A offset, both modes
// RQ3: core B input B offset, both modes
// RQ4: fine gain core A bank 0, dual mode
// RQ5: fine gain core A bank 1, dual mode
// RQ6: fine gain core B bank 0, dual mode
// RQ7: fine gain core B bank 1, dual mode
// RQ8: defaults load from fuse storage
// RQ9: reads return stored value, reserved bits kept
`ifndef TRIM_BANK_CFG_SVH
`define TRIM_BANK_CFG_SVH
`define ADDR_W 12
`define OFS_A90_INB 12'h34A
`define OFS_B_INA 12'h34C
`define OFS_B_INB 12'h34E
`define GAIN_A0 12'h350
`define GAIN_A1 12'h351
`define GAIN_B0 12'h352
`define GAIN_B1 12'h353
`define OFS_W 16
`define OFS_FIELD_W 12
`define GAIN_W 8
`define GAIN_FIELD_W 5
`define OFS_RESET 16'h0000
`define GAIN_RESET 8'h00
`endif

// ### include/trim_bank_pkg.sv
// types for the trim bank
package trim_bank_pkg;
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_A90_INB,
        SEL_B_INA,
        SEL_B_INB
    } offset_sel_t;
    typedef logic [15:0] word_t;
endpackage

// ### design/trim_bank.sv
// offset and fine-gain trim register bank with correction outputs
//
// Strobed register access was decided locally.
`include "trim_bank_cfg.svh"

module trim_bank #(
    parameter int ADDR_W = `ADDR_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rdata,
    input wire logic fuse_load,
    input wire logic [15:0] fuse_ofs_a90_inb,
    input wire logic [15:0] fuse_ofs_b_ina,
    input wire logic [15:0] fuse_ofs_b_inb,
    input wire logic [7:0] fuse_gain_a0,
    input wire logic [7:0] fuse_gain_a1,
    input wire logic [7:0] fuse_gain_b0,
    input wire logic [7:0] fuse_gain_b1,
    input wire logic fg_cal_en,
    input wire logic dual_mode,
    input wire logic core_a_phase90,
    input wire logic core_a_on_input_b,
    input wire logic core_b_on_input_b,
    output logic [11:0] core_a_offset,
    output logic [11:0] core_b_offset,
    output logic [4:0] core_a_bank0_gain,
    output logic [4:0] core_a_bank1_gain,
    output logic [4:0] core_b_bank0_gain,
    output logic [4:0] core_b_bank1_gain
);

    // the map decode needs the full documented address width
    if (ADDR_W < `ADDR_W) begin : g_addr_chk
        $error("trim_bank: address too narrow for map");
    end

    logic [15:0] offset_trim_core_a_phase90_input_b_r;
    logic [15:0] offset_trim_core_b_input_a_r;
    logic [15:0] offset_trim_core_b_input_b_r;
    logic [7:0] fine_gain_core_a_bank0_dual_r;
    logic [7:0] fine_gain_core_a_bank1_dual_r;
    logic [7:0] fine_gain_core_b_bank0_dual_r;
    logic [7:0] fine_gain_core_b_bank1_dual_r;
    logic [11:0] a_addr;

    assign a_addr = addr[11:0];

    // fuse load wins over a write in the same cycle so factory values land
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            offset_trim_core_a_phase90_input_b_r <= `OFS_RESET;
            offset_trim_core_b_input_a_r <= `OFS_RESET;
            offset_trim_core_b_input_b_r <= `OFS_RESET;
        end else if (clk_en) begin
            if (fuse_load) begin
                offset_trim_core_a_phase90_input_b_r <= fuse_ofs_a90_inb; // see RQ8
                offset_trim_core_b_input_a_r <= fuse_ofs_b_ina; // see RQ8
                offset_trim_core_b_input_b_r <= fuse_ofs_b_inb; // see RQ8
            end else if (wr_stb) begin
                unique case (a_addr)
                    `OFS_A90_INB: offset_trim_core_a_phase90_input_b_r <= wdata;
                    `OFS_B_INA: offset_trim_core_b_input_a_r <= wdata;
                    `OFS_B_INB: offset_trim_core_b_input_b_r <= wdata;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fine_gain_core_a_bank0_dual_r <= `GAIN_RESET;
            fine_gain_core_a_bank1_dual_r <= `GAIN_RESET;
            fine_gain_core_b_bank0_dual_r <= `GAIN_RESET;
            fine_gain_core_b_bank1_dual_r <= `GAIN_RESET;
        end else if (clk_en) begin
            if (fuse_load) begin
                fine_gain_core_a_bank0_dual_r <= fuse_gain_a0; // see RQ8
                fine_gain_core_a_bank1_dual_r <= fuse_gain_a1; // see RQ8
                fine_gain_core_b_bank0_dual_r <= fuse_gain_b0; // see RQ8
                fine_gain_core_b_bank1_dual_r <= fuse_gain_b1; // see RQ8
            end else if (wr_stb) begin
                unique case (a_addr)
                    `GAIN_A0: fine_gain_core_a_bank0_dual_r <= wdata[7:0];
                    `GAIN_A1: fine_gain_core_a_bank1_dual_r <= wdata[7:0];
                    `GAIN_B0: fine_gain_core_b_bank0_dual_r <= wdata[7:0];
                    `GAIN_B1: fine_gain_core_b_bank1_dual_r <= wdata[7:0];
                    default: ;
                endcase
            end
        end
    end

    // read data valid after an enabled strobe, zero after other enabled cycles, held while clk_en is low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata <= 16'h0000;
        end else if (clk_en) begin
            rdata <= 16'h0000;
            if (rd_stb) begin
                unique case (a_addr)
                    `OFS_A90_INB: rdata <= offset_trim_core_a_phase90_input_b_r; // see RQ9
                    `OFS_B_INA: rdata <= offset_trim_core_b_input_a_r; // see RQ9
                    `OFS_B_INB: rdata <= offset_trim_core_b_input_b_r; // see RQ9
                    `GAIN_A0: rdata <= {8'h00, fine_gain_core_a_bank0_dual_r};
                    `GAIN_A1: rdata <= {8'h00, fine_gain_core_a_bank1_dual_r};
                    `GAIN_B0: rdata <= {8'h00, fine_gain_core_b_bank0_dual_r};
                    `GAIN_B1: rdata <= {8'h00, fine_gain_core_b_bank1_dual_r};
                    default: rdata <= 16'h0000;
                endcase
            end
        end
    end

    trim_bank_pkg::offset_sel_t a_sel;
    trim_bank_pkg::offset_sel_t b_sel;

    always_comb begin
        a_sel = trim_bank_pkg::SEL_NONE;
        if (fg_cal_en && core_a_phase90 && core_a_on_input_b) begin
            a_sel = trim_bank_pkg::SEL_A90_INB; // see RQ1
        end
        b_sel = trim_bank_pkg::SEL_NONE;
        if (fg_cal_en) begin
            b_sel = core_b_on_input_b ? trim_bank_pkg::SEL_B_INB
                                      : trim_bank_pkg::SEL_B_INA;
        end
    end

    // reserved upper bits never reach the correction path
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            core_a_offset <= 12'h000;
            core_b_offset <= 12'h000;
        end else if (clk_en) begin
            core_a_offset <= (a_sel == trim_bank_pkg::SEL_A90_INB)
                ? offset_trim_core_a_phase90_input_b_r[11:0] : 12'h000; // see RQ1
            unique case (b_sel)
                trim_bank_pkg::SEL_B_INA:
                    core_b_offset <= offset_trim_core_b_input_a_r[11:0]; // see RQ2
                trim_bank_pkg::SEL_B_INB:
                    core_b_offset <= offset_trim_core_b_input_b_r[11:0]; // see RQ3
                default: core_b_offset <= 12'h000;
            endcase
        end
    end

    // gains drive only in dual mode; single-mode trims live elsewhere
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            core_a_bank0_gain <= 5'h00;
            core_a_bank1_gain <= 5'h00;
            core_b_bank0_gain <= 5'h00;
            core_b_bank1_gain <= 5'h00;
        end else if (clk_en) begin
            core_a_bank0_gain <= dual_mode
                ? fine_gain_core_a_bank0_dual_r[4:0] : 5'h00; // see RQ4
            core_a_bank1_gain <= dual_mode
                ? fine_gain_core_a_bank1_dual_r[4:0] : 5'h00; // see RQ5
            core_b_bank0_gain <= dual_mode
                ? fine_gain_core_b_bank0_dual_r[4:0] : 5'h00; // see RQ6
            core_b_bank1_gain <= dual_mode
                ? fine_gain_core_b_bank1_dual_r[4:0] : 5'h00; // see RQ7
        end
    end

    a_a90_gated: assert property (@(posedge sys_clk) disable iff (rst) // see RQ1
        clk_en && !fg_cal_en |=> core_a_offset == 12'h000)
        else $error("core A offset applied without calibration");

    a_a90_applied: assert property (@(posedge sys_clk) disable iff (rst) // see RQ1
        clk_en && fg_cal_en && core_a_phase90 && core_a_on_input_b
        |=> core_a_offset == $past(offset_trim_core_a_phase90_input_b_r[11:0]))
        else $error("core A offset not applied");

    a_b_ina: assert property (@(posedge sys_clk) disable iff (rst) // see RQ2
        clk_en && fg_cal_en && !core_b_on_input_b
        |=> core_b_offset == $past(offset_trim_core_b_input_a_r[11:0]))
        else $error("core B input A offset wrong");

    a_b_inb: assert property (@(posedge sys_clk) disable iff (rst) // see RQ3
        clk_en && fg_cal_en && core_b_on_input_b
        |=> core_b_offset == $past(offset_trim_core_b_input_b_r[11:0]))
        else $error("core B input B offset wrong");

    a_gain_a0: assert property (@(posedge sys_clk) disable iff (rst) // see RQ4
        clk_en && wr_stb && !fuse_load && a_addr == `GAIN_A0 && dual_mode
        ##1 clk_en && dual_mode && !wr_stb && !fuse_load
        |=> core_a_bank0_gain == $past(wdata[4:0], 2))
        else $error("gain A0 write not applied");

    a_gain_a1: assert property (@(posedge sys_clk) disable iff (rst) // see RQ5
        clk_en && dual_mode |=> core_a_bank1_gain
            == $past(fine_gain_core_a_bank1_dual_r[4:0]))
        else $error("gain A1 not applied");

    a_gain_b0: assert property (@(posedge sys_clk) disable iff (rst) // see RQ6
        clk_en && dual_mode |=> core_b_bank0_gain
            == $past(fine_gain_core_b_bank0_dual_r[4:0]))
        else $error("gain B0 not applied");

    a_gain_b1: assert property (@(posedge sys_clk) disable iff (rst) // see RQ7
        clk_en && dual_mode |=> core_b_bank1_gain
            == $past(fine_gain_core_b_bank1_dual_r[4:0]))
        else $error("gain B1 not applied");

    a_fuse_load: assert property (@(posedge sys_clk) disable iff (rst) // see RQ8
        clk_en && fuse_load |=> offset_trim_core_b_input_a_r
            == $past(fuse_ofs_b_ina))
        else $error("fuse value not loaded");

    a_read_back: assert property (@(posedge sys_clk) disable iff (rst) // see RQ9
        clk_en && wr_stb && !fuse_load && a_addr == `OFS_B_INB
        ##1 clk_en && !wr_stb && !fuse_load
        ##1 clk_en && rd_stb && !wr_stb && !fuse_load && a_addr == `OFS_B_INB
        |=> rdata == $past(wdata, 3))
        else $error("read back differs from write");

    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (rst) // see RQ9
        clk_en && !rd_stb |=> rdata == 16'h0000)
        else $error("read data not cleared after read");

    a_gain_upper: assert property (@(posedge sys_clk) disable iff (rst) // see RQ9
        clk_en && rd_stb && a_addr == `GAIN_B1 |=> rdata[15:8] == 8'h00)
        else $error("gain read shows upper byte");

    a_wr_a90: assert property (@(posedge sys_clk) disable iff (rst) // see RQ9
        clk_en && wr_stb && !fuse_load && a_addr == `OFS_A90_INB
        |=> offset_trim_core_a_phase90_input_b_r == $past(wdata))
        else $error("offset write not stored");

    a_wr_gain_b1: assert property (@(posedge sys_clk) disable iff (rst) // see RQ7
        clk_en && wr_stb && !fuse_load && a_addr == `GAIN_B1
        |=> fine_gain_core_b_bank1_dual_r == $past(wdata[7:0]))
        else $error("gain write not stored");

    a_fuse_wins: assert property (@(posedge sys_clk) disable iff (rst) // see RQ8
        clk_en && fuse_load && wr_stb
        |=> offset_trim_core_a_phase90_input_b_r == $past(fuse_ofs_a90_inb))
        else $error("write beat fuse load");

    a_b_gated: assert property (@(posedge sys_clk) disable iff (rst) // see RQ2
        clk_en && !fg_cal_en |=> core_b_offset == 12'h000)
        else $error("core B offset applied without calibration");

    a_a90_other: assert property (@(posedge sys_clk) disable iff (rst) // see RQ1
        clk_en && !(core_a_phase90 && core_a_on_input_b)
        |=> core_a_offset == 12'h000)
        else $error("core A offset applied off its phase");

    a_gain_single: assert property (@(posedge sys_clk) disable iff (rst) // see RQ4
        clk_en && !dual_mode |=> core_a_bank0_gain == 5'h00
            && core_a_bank1_gain == 5'h00 && core_b_bank0_gain == 5'h00
            && core_b_bank1_gain == 5'h00)
        else $error("gain applied outside dual mode");

    // a frozen block must hold its outputs; read data, both offsets and the core A bank 0 gain are checked
    a_freeze: assert property (@(posedge sys_clk) disable iff (rst) // see RQ9
        !clk_en |=> $stable(rdata) && $stable(core_a_offset)
            && $stable(core_b_offset) && $stable(core_a_bank0_gain))
        else $error("state moved while clock enable low");

endmodule

// ### tb/tb_top.sv
// self-checking bench for the offset and fine-gain trim bank
`include "trim_bank_cfg.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst, clk_en, wr_stb, rd_stb, fuse_load;
    logic fg_cal_en, dual_mode, a_ph90, a_inb, b_inb;
    logic [11:0] addr;
    logic [15:0] wdata, rdata, v;
    logic [15:0] fz [7];
    logic [15:0] wv [7];
    logic [11:0] map [7];
    logic [11:0] ofs_a, ofs_b;
    logic [4:0] g_a0, g_a1, g_b0, g_b1;
    int err_count = 0;
    int check_count = 0;

    trim_bank DUT (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .fuse_load(fuse_load), .fuse_ofs_a90_inb(fz[0]),
        .fuse_ofs_b_ina(fz[1]), .fuse_ofs_b_inb(fz[2]),
        .fuse_gain_a0(fz[3][7:0]), .fuse_gain_a1(fz[4][7:0]),
        .fuse_gain_b0(fz[5][7:0]), .fuse_gain_b1(fz[6][7:0]),
        .fg_cal_en(fg_cal_en), .dual_mode(dual_mode),
        .core_a_phase90(a_ph90), .core_a_on_input_b(a_inb),
        .core_b_on_input_b(b_inb), .core_a_offset(ofs_a),
        .core_b_offset(ofs_b), .core_a_bank0_gain(g_a0),
        .core_a_bank1_gain(g_a1), .core_b_bank0_gain(g_b0),
        .core_b_bank1_gain(g_b1));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // gain words are eight bits wide, upper byte reads zero
    function automatic logic [15:0] msk(input int i);
        return (i > 2) ? 16'h00FF : 16'hFFFF;
    endfunction

    task automatic chk(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask

    // outputs are registered behind the stored words, allow a few edges
    task automatic settle();
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge sys_clk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        map = '{`OFS_A90_INB, `OFS_B_INA, `OFS_B_INB, `GAIN_A0, `GAIN_A1,
                `GAIN_B0, `GAIN_B1};
        for (int i = 0; i < 7; i++) begin
            fz[i] = 16'hF123 + 16'(i) * 16'h1111;
            wv[i] = 16'h9ABC ^ (16'(i) * 16'h1357);
        end
        rst = 1'b1;
        clk_en = 1'b1;
        {wr_stb, rd_stb, fuse_load, fg_cal_en, dual_mode} = 5'h00;
        {a_ph90, a_inb, b_inb} = 3'h0;
        addr = 12'h000;
        wdata = 16'h0000;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(map[i], v);
            chk("reset value", v, 16'h0000);
        end
        @(posedge sys_clk);
        fuse_load <= 1'b1;
        addr <= map[0];
        wdata <= 16'h5555;
        wr_stb <= 1'b1;
        @(posedge sys_clk);
        fuse_load <= 1'b0;
        wr_stb <= 1'b0;
        dual_mode <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(map[i], v);
            chk("fuse default", v, fz[i] & msk(i));
        end
        @(posedge sys_clk);
        #1;
        chk("rdata idle", rdata, 16'h0000);
        for (int i = 0; i < 7; i++) begin
            wr(map[i], wv[i]);
            rd(map[i], v);
            chk("readback", v, wv[i] & msk(i));
        end
        // unmapped hole between two offset words
        wr(12'h34B, 16'hFFFF);
        rd(12'h34B, v);
        chk("unmapped read", v, 16'h0000);
        rd(map[0], v);
        chk("neighbour kept", v, wv[0]);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(map[1], 16'h1234);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rd(map[1], v);
        chk("frozen write", v, wv[1]);
        @(posedge sys_clk);
        {fg_cal_en, dual_mode, a_ph90, a_inb, b_inb} <= 5'b11110;
        settle();
        chk("core a offset", 16'(ofs_a), wv[0] & 16'h0FFF);
        chk("core b offset a", 16'(ofs_b), wv[1] & 16'h0FFF);
        chk("gain a0", 16'(g_a0), wv[3] & 16'h001F);
        chk("gain a1", 16'(g_a1), wv[4] & 16'h001F);
        chk("gain b0", 16'(g_b0), wv[5] & 16'h001F);
        chk("gain b1", 16'(g_b1), wv[6] & 16'h001F);
        {dual_mode, b_inb} <= 2'b01;
        settle();
        chk("core b offset b", 16'(ofs_b), wv[2] & 16'h0FFF);
        chk("single gain", 16'(g_a0 | g_a1 | g_b0 | g_b1), 16'h0000);
        a_ph90 <= 1'b0;
        settle();
        chk("core a phase0", 16'(ofs_a), 16'h0000);
        fg_cal_en <= 1'b0;
        {a_ph90, b_inb} <= 2'b10;
        settle();
        chk("cal off a", 16'(ofs_a), 16'h0000);
        chk("cal off b", 16'(ofs_b), 16'h0000);
        tally_and_finish();
    end
endmodule
